//--- logic/cstsel_top.sv
// module: selects and times the capture of counter and inputs into process data
`timescale 1ns/100ps
module cstsel_top
  import cstsel_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_ce,
  input  wire cstsel_pkg::cstsel_cfg_t i_cfg,
  input  wire logic                   i_process_data_exchange_event,
  input  wire logic                   i_frame_start,
  input  wire logic [CNT_W-1:0]       i_count,
  input  wire logic [IN_W-1:0]        i_inputs_raw,
  input  wire logic [IN_W-1:0]        i_inputs_filt,
  output logic                        o_cyclic_sync_pulse,
  output cstsel_pkg::cstsel_snap_t    o_snap,
  output logic                        o_capture_late
);
  import cstsel_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // sync pulse generator and shifted capture instant
  // ---------------------------------------------------------------
  logic [CYCLE_W-1:0] cyc_cnt_q, cyc_cnt_d;
  logic               sync_d, sync_q;
  logic [CYCLE_W-1:0] dly_cnt_q, dly_cnt_d;
  logic               dly_busy_q, dly_busy_d;
  logic               trig;
  logic signed [SHIFT_W-1:0] shift_cyc;
  logic [CYCLE_W-1:0] base_pt;

  // ns steps truncate to whole cycles; finer steps cannot be resolved here
  assign shift_cyc = i_cfg.shift_ns / SHIFT_W'(CLK_PERIOD_NS);

  always_comb begin
    base_pt   = '0;
    sync_d    = 1'b0;
    cyc_cnt_d = cyc_cnt_q;
    dly_cnt_d = dly_cnt_q;
    dly_busy_d = dly_busy_q;
    trig      = 1'b0;
    // cycle period programmed by the master to the bus cycle
    if (i_cfg.cycle_cyc == '0 || cyc_cnt_q >= i_cfg.cycle_cyc - 1'b1) begin
      cyc_cnt_d = '0;
    end else begin
      cyc_cnt_d = cyc_cnt_q + 1'b1;
    end
    // negative shift: fire ahead of the nominal wrap point
    if (shift_cyc < 0) begin
      base_pt = i_cfg.cycle_cyc - CYCLE_W'(-shift_cyc);
      sync_d  = (cyc_cnt_q == base_pt);
    end else begin
      sync_d  = (cyc_cnt_q == '0);
    end
    if (sync_q && shift_cyc > 0) begin
      dly_busy_d = 1'b1;
      dly_cnt_d  = CYCLE_W'(shift_cyc);
    end else if (dly_busy_q) begin
      dly_cnt_d = dly_cnt_q - 1'b1;
      if (dly_cnt_q == CYCLE_W'(1)) begin
        dly_busy_d = 1'b0;
      end
    end
    if (i_cfg.clk_mode) begin
      trig = (shift_cyc > 0) ? (dly_busy_q && dly_cnt_q == CYCLE_W'(1)) : sync_q;
    end else begin
      trig = i_process_data_exchange_event;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cyc_cnt_q  <= CYCLE_RST;
      sync_q     <= 1'b0;
      dly_cnt_q  <= CYCLE_RST;
      dly_busy_q <= 1'b0;
    end else if (i_ce) begin
      cyc_cnt_q  <= cyc_cnt_d;
      sync_q     <= sync_d;
      dly_cnt_q  <= dly_cnt_d;
      dly_busy_q <= dly_busy_d;
    end
  end

  // ---------------------------------------------------------------
  // capture pipeline and process data snapshot
  // ---------------------------------------------------------------
  logic [CAPT_LAT_CYC-1:0] pipe_q, pipe_d;
  cstsel_snap_t stage_q, stage_d;
  cstsel_snap_t stage2_q, stage2_d;
  cstsel_snap_t snap_q, snap_d;
  logic         late_q, late_d;
  logic         pend_q, pend_d;
  logic         sync_out_q;
  logic         wait_cap;

  // a shifted capture still counting down leaves no current value either
  assign wait_cap = pend_q || (i_cfg.clk_mode && dly_busy_q);

  always_comb begin
    pipe_d  = {pipe_q[CAPT_LAT_CYC-2:0], trig};
    stage_d = stage_q;
    stage2_d = stage2_q;
    snap_d  = snap_q;
    late_d  = late_q;
    pend_d  = pend_q;
    if (trig) begin
      stage_d.count  = i_count;
      // unfiltered inputs in clock mode for the freshest edge
      stage_d.inputs = i_cfg.clk_mode ? i_inputs_raw : i_inputs_filt;
      stage_d.fresh  = 1'b1;
      pend_d         = 1'b1;
    end
    // second stage keeps a back-to-back trigger from overwriting the first capture
    if (pipe_q[0]) begin
      stage2_d = stage_q;
    end
    if (pipe_q[CAPT_LAT_CYC-1]) begin
      snap_d = stage2_q;
      pend_d = trig;
    end
    if (i_frame_start) begin
      // frame arrived while capture still in flight: no current value
      late_d       = wait_cap && !pipe_q[CAPT_LAT_CYC-1];
      snap_d.fresh = pipe_q[CAPT_LAT_CYC-1] ? 1'b1 : (snap_q.fresh && !wait_cap);
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pipe_q     <= '0;
      stage_q    <= '{count: CNT_RST, inputs: IN_RST, fresh: 1'b0};
      stage2_q   <= '{count: CNT_RST, inputs: IN_RST, fresh: 1'b0};
      snap_q     <= '{count: CNT_RST, inputs: IN_RST, fresh: 1'b0};
      late_q     <= 1'b0;
      pend_q     <= 1'b0;
      sync_out_q <= 1'b0;
    end else if (i_ce) begin
      pipe_q     <= pipe_d;
      stage_q    <= stage_d;
      stage2_q   <= stage2_d;
      snap_q     <= snap_d;
      late_q     <= late_d;
      pend_q     <= pend_d;
      sync_out_q <= sync_q;
    end
  end

  assign o_snap              = snap_q;
  assign o_capture_late      = late_q;
  assign o_cyclic_sync_pulse = sync_out_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_frame_capture;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_ce && !i_cfg.clk_mode && i_process_data_exchange_event) |=> pipe_q[0];
  endproperty
  a_frame_capture: assert property (p_frame_capture) else $error("frame trigger lost");

  property p_clock_capture;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_ce && i_cfg.clk_mode && shift_cyc <= 0 && sync_q) |=> pipe_q[0];
  endproperty
  a_clock_capture: assert property (p_clock_capture) else $error("sync trigger lost");

  property p_snap_update;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_ce && pipe_q[CAPT_LAT_CYC-1]) |=> (o_snap.count == $past(stage2_q.count));
  endproperty
  a_snap_update: assert property (p_snap_update) else $error("snapshot not taken");

  property p_snap_stable;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (!pipe_q[CAPT_LAT_CYC-1]) |=> $stable(o_snap.count) && $stable(o_snap.inputs);
  endproperty
  a_snap_stable: assert property (p_snap_stable) else $error("snapshot changed");

  property p_raw_inputs;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_ce && trig && i_cfg.clk_mode) |=> (stage_q.inputs == $past(i_inputs_raw));
  endproperty
  a_raw_inputs: assert property (p_raw_inputs) else $error("filtered input in clock mode");

  property p_shift_delay;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_ce && sync_q && shift_cyc > 0) |=> dly_busy_q && dly_cnt_q == CYCLE_W'($past(shift_cyc));
  endproperty
  a_shift_delay: assert property (p_shift_delay) else $error("shift delay not loaded");

  property p_late_flag;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_ce && i_frame_start && wait_cap && !pipe_q[CAPT_LAT_CYC-1]) |=> o_capture_late;
  endproperty
  a_late_flag: assert property (p_late_flag) else $error("late capture not flagged");

  property p_sync_out;
    @(posedge i_core_clk) disable iff (!rst_n_q)
    (i_ce && sync_q) |=> o_cyclic_sync_pulse;
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("sync pulse not forwarded");

  c_frame: cover property (@(posedge i_core_clk) disable iff (!rst_n_q)
    !i_cfg.clk_mode && pipe_q[CAPT_LAT_CYC-1]);
  c_clock: cover property (@(posedge i_core_clk) disable iff (!rst_n_q)
    i_cfg.clk_mode && pipe_q[CAPT_LAT_CYC-1]);
  c_late: cover property (@(posedge i_core_clk) disable iff (!rst_n_q) o_capture_late);
endmodule : cstsel_top

//--- logic/cstsel_pkg.sv
// package: constants and types for the counter sample trigger select block
package cstsel_pkg;
  localparam int CNT_W       = 32;
  localparam int IN_W        = 8;
  localparam int SHIFT_W     = 32;
  localparam int CYCLE_W     = 32;
  // capture pipeline latency in clock cycles after the trigger instant
  localparam int CAPT_LAT_CYC = 2;
  localparam logic [CNT_W-1:0]   CNT_RST   = 32'h0000_0000;
  localparam logic [IN_W-1:0]    IN_RST    = 8'h00;
  localparam logic [CYCLE_W-1:0] CYCLE_RST = 32'h0000_0000;
  // clock period in ns; shift is given in ns and converted to cycles
  localparam int CLK_PERIOD_NS = 25;

  typedef enum logic [1:0] {
    CSTSEL_MODE_FRAME = 2'h1,
    CSTSEL_MODE_CLOCK = 2'h2
  } cstsel_mode_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [IN_W-1:0]  inputs;
    logic             fresh;
  } cstsel_snap_t;

  typedef struct packed {
    logic                      clk_mode;
    logic [CYCLE_W-1:0]        cycle_cyc;
    logic signed [SHIFT_W-1:0] shift_ns;
  } cstsel_cfg_t;
endpackage : cstsel_pkg

//--- tb/cstsel_master_model.sv
// partner: fieldbus master that polls process data and sets the sync cycle
`timescale 1ns/100ps
module cstsel_master_model
  import cstsel_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_run,
  input  wire logic               i_kick,
  input  wire logic               i_mode,
  input  wire logic [7:0]         i_period,
  input  wire logic signed [31:0] i_shift,
  output cstsel_pkg::cstsel_cfg_t o_cfg,
  output logic                    o_xchg,
  output logic                    o_poll
);
  logic [7:0] cnt_q = 8'h00;
  logic       poll_q = 1'b0;
  logic       xchg_q = 1'b0;
  // sync cycle follows the bus cycle
  assign o_cfg = '{i_mode, {24'h0, i_period}, i_shift};
  // kick forces an extra poll in the same cycle
  assign o_poll = poll_q | i_kick;
  assign o_xchg = xchg_q;
  always @(posedge i_clk) begin
    #2;
    cnt_q = (!i_run || cnt_q == i_period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    poll_q = i_run && cnt_q == 8'h00;
    xchg_q = i_run && cnt_q == 8'h03;
  end
endmodule : cstsel_master_model

//--- tb/testbench.sv
// testbench: random traffic and capture checks for the trigger select block
`timescale 1ns/100ps
module testbench;
  import cstsel_pkg::*;
  logic               clk = 0, rst_n = 0, run = 0, kick = 0, mode = 0;
  logic [7:0]         per = 8'h0c, raw = 8'h00, filt = 8'h00, hi [0:2];
  logic signed [31:0] shift = 32'sh0, sh_p = 32'sh0, lsh = 32'sh0;
  logic [31:0]        rng = 32'h0000_004e, cnt = 32'h0, hc [0:2];
  logic [2:0]         ht = 3'h0;
  logic               xchg, poll, sync, late, ce = 1'b1, mode_p = 1'b0;
  cstsel_cfg_t        cfg;
  cstsel_snap_t       snap, held;
  int                 fail_count = 0, total_checks = 0, cyc = 0, last = 0;
  int                 dcnt = 0, nsync = 0;
  always #12.5 clk = ~clk;
  cstsel_master_model cstsel_master_model_i (.i_clk(clk), .i_run(run), .i_kick(kick),
    .i_mode(mode), .i_period(per), .i_shift(shift), .o_cfg(cfg), .o_xchg(xchg), .o_poll(poll));
  cstsel_top cstsel_top_i (.i_core_clk(clk), .i_resetn(rst_n), .i_ce(ce), .i_cfg(cfg),
    .i_process_data_exchange_event(xchg), .i_frame_start(poll), .i_count(cnt),
    .i_inputs_raw(raw), .i_inputs_filt(filt), .o_cyclic_sync_pulse(sync), .o_snap(snap),
    .o_capture_late(late));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : next_rand
  // whole clock cycles that a positive shift adds before the capture
  function automatic int exp_delay(input logic signed [31:0] s);
    return (s > 0) ? int'(s / CLK_PERIOD_NS) : 0;
  endfunction : exp_delay
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // ---
  // stimulus and monitor
  // ---
  always @(posedge clk) begin
    #2;
    rng = next_rand(rng);
    cnt = (rng[4:0] == 5'h00) ? 32'hffff_ffff : rng;
    raw = rng[7:0];
    filt = rng[15:8];
  end
  always @(posedge clk) begin
    if (cyc > 6000) begin
      fail_count++;
      close_out;
    end
  end
  // history of what the block saw, so a capture landing two edges on can be judged
  always @(posedge clk) begin
    cyc++;
    for (int i = 2; i > 0; i--) begin
      hc[i] = hc[i-1];
      hi[i] = hi[i-1];
    end
    hc[0] = cnt;
    hi[0] = mode ? raw : filt;
    ht = {ht[1:0], !mode && xchg};
    if (dcnt > 0) begin
      dcnt--;
      if (dcnt == 0) ht[1] = 1'b1;
    end
    // pulse seen now: sync instant was one edge ago, under that cycle's mode and shift
    if (mode_p && sync && rst_n) begin
      if (exp_delay(sh_p) == 0) ht[1] = 1'b1;
      else dcnt = exp_delay(sh_p);
      if (last > 0 && lsh == sh_p) chk(41'(cyc - last), 41'(per));
      last = cyc;
      lsh = sh_p;
    end
    mode_p = mode;
    sh_p = shift;
    #1;
    if (ht[2] && rst_n) chk(snap, {hc[2], hi[2], 1'b1});
  end
  initial begin
    per = 8'h06 + {4'h0, rng[3:0]};
    repeat (10) @(posedge clk);
    #2 rst_n = 1;
    repeat (4) @(posedge clk);
    #2 run = 1;
    repeat (400) @(posedge clk);
    for (int m = 0; m < 3; m++) begin
      #2 mode = 1;
      shift = (m == 1) ? -32'sd60 : (m == 2) ? 32'sd80 : 32'sd0;
      last = 0;
      repeat (300) @(posedge clk);
    end
    #2 run = 0;
    // poll while the shifted capture is still counting down
    @(posedge sync);
    #2 kick = 1;
    @(posedge clk);
    #2 kick = 0;
    chk(41'(late), 41'(1));
    chk(41'(snap.fresh), 41'(0));
    // poll after the capture has landed
    @(posedge sync);
    repeat (exp_delay(shift) + CAPT_LAT_CYC) @(posedge clk);
    #2 kick = 1;
    @(posedge clk);
    #2 kick = 0;
    chk(41'(late), 41'(0));
    chk(41'(snap.fresh), 41'(1));
    // clock enable low freezes the sync counter and the snapshot
    ce = 1'b0;
    held = snap;
    repeat (30) begin
      @(posedge clk);
      if (sync) nsync++;
    end
    #2;
    chk(41'(nsync), 41'(0));
    chk(snap, held);
    close_out;
  end
endmodule : testbench
